/* File: common/rtor_map.svh */
/*
 * Register map, field positions and reset values of the real-time output router.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef RTOR_MAP_SVH
`define RTOR_MAP_SVH

`define RTOR_ADDR_W          20
`define RTOR_OFS_SRC_SEL     20'hF_01C0
`define RTOR_OFS_CUT_EN      20'hF_01C1
`define RTOR_OFS_CTRL_LOW    20'hF_01C2
`define RTOR_OFS_CTRL_HIGH   20'hF_01C3
`define RTOR_OFS_CUT_STATE   20'hF_01C4
`define RTOR_OFS_CUT_STATUS  20'hF_01C5
`define RTOR_RESET_VAL       8'h00
`define RTOR_ENA_LSB         0
`define RTOR_INV_LSB         4
`define RTOR_FLAG_BIT        1
`define RTOR_CLR_BIT         0

`endif

/* File: common/rtor_pkg.sv */
/*
 * Types of the real-time output router.
 * Assumes rtor_map.svh is on the include path.
 */
package rtor_pkg;
    // Per-group state chosen while a cutoff is active
    typedef enum logic [1:0] {
        CUT_HIZ,
        CUT_LOW,
        CUT_HIGH,
        CUT_NONE
    } rtor_cut_type;
    // Register selector decoded from the bus address
    typedef enum logic [2:0] {
        SEL_SRC,
        SEL_CUT_EN,
        SEL_CTRL_LOW,
        SEL_CTRL_HIGH,
        SEL_CUT_STATE,
        SEL_CUT_STATUS,
        SEL_NONE
    } rtor_sel_type;
endpackage

/* File: core/rtor_top.sv */
/*
 * Real-time output router: eight output pins, each sourced from one of two
 * timer waveforms, optionally inverted, gated, and overridden by a forced cutoff.
 * Assumes a synchronous CPU byte bus with a bit-write mask, and timer
 * waveforms and the cutoff event synchronous to I_SYS_CLK.
 */
`timescale 1ns/100ps
`include "rtor_map.svh"
module rtor_top
    import rtor_pkg::*;
(
    input  wire logic                     I_SYS_CLK,
    input  wire logic                     I_NRST,
    input  wire logic                     I_CLK_EN,
    input  wire logic [`RTOR_ADDR_W-1:0]  I_ADDR,
    input  wire logic                     I_WR,
    input  wire logic                     I_RD,
    input  wire logic [7:0]               I_WMASK,
    input  wire logic [7:0]               I_WDATA,
    input  wire logic [7:0]               I_TIMER_WAVE_A,
    input  wire logic [7:0]               I_TIMER_WAVE_B,
    input  wire logic                     I_EXTERNAL_CUTOFF_EVENT,
    output logic      [7:0]               O_RDATA,
    output logic      [7:0]               O_PIN_OUT,
    output logic      [7:0]               O_PIN_OE
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_sync_r;
    logic       rst_n;

    // Two stages so release is clean against the clock
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    rtor_sel_type sel;
    logic [7:0]   src_sel_r;
    logic [7:0]   cut_en_r;
    logic [7:0]   ctrl_low_r;
    logic [7:0]   ctrl_high_r;
    logic [7:0]   cut_state_r;
    logic         cut_flag_r;

    always_comb begin
        unique case (I_ADDR)
            `RTOR_OFS_SRC_SEL:    sel = SEL_SRC;
            `RTOR_OFS_CUT_EN:     sel = SEL_CUT_EN;
            `RTOR_OFS_CTRL_LOW:   sel = SEL_CTRL_LOW;
            `RTOR_OFS_CTRL_HIGH:  sel = SEL_CTRL_HIGH;
            `RTOR_OFS_CUT_STATE:  sel = SEL_CUT_STATE;
            `RTOR_OFS_CUT_STATUS: sel = SEL_CUT_STATUS;
            default:              sel = SEL_NONE;
        endcase
    end

    // Masked write helper: only bits set in the mask change
    function automatic logic [7:0] merge(input logic [7:0] old_v);
        merge = (old_v & ~I_WMASK) | (I_WDATA & I_WMASK);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    // byte or bit writes via mask
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            src_sel_r   <= `RTOR_RESET_VAL;
            cut_en_r    <= `RTOR_RESET_VAL;
            ctrl_low_r  <= `RTOR_RESET_VAL;
            ctrl_high_r <= `RTOR_RESET_VAL;
            cut_state_r <= `RTOR_RESET_VAL;
        end else if (I_CLK_EN && I_WR) begin
            unique case (sel)
                SEL_SRC:       src_sel_r   <= merge(src_sel_r);
                SEL_CUT_EN:    cut_en_r    <= merge(cut_en_r);
                SEL_CTRL_LOW:  ctrl_low_r  <= merge(ctrl_low_r);
                SEL_CTRL_HIGH: ctrl_high_r <= merge(ctrl_high_r);
                SEL_CUT_STATE: cut_state_r <= merge(cut_state_r);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cutoff status flag

    logic clr_req;
    assign clr_req = I_WR && (sel == SEL_CUT_STATUS)
                     && I_WMASK[`RTOR_CLR_BIT] && I_WDATA[`RTOR_CLR_BIT];

    // write-one clears; a new event in the same cycle wins
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cut_flag_r <= 1'b0;
        end else if (I_CLK_EN) begin
            if (I_EXTERNAL_CUTOFF_EVENT) begin
                cut_flag_r <= 1'b1;
            end else if (clr_req && cut_flag_r) begin
                cut_flag_r <= 1'b0;
            end
        end
    end

    // Read data is registered; clear bit and upper status bits read zero
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_RDATA <= 8'h00;
        end else if (I_CLK_EN && I_RD) begin
            unique case (sel)
                SEL_SRC:        O_RDATA <= src_sel_r;
                SEL_CUT_EN:     O_RDATA <= cut_en_r;
                SEL_CTRL_LOW:   O_RDATA <= ctrl_low_r;
                SEL_CTRL_HIGH:  O_RDATA <= ctrl_high_r;
                SEL_CUT_STATE:  O_RDATA <= cut_state_r;
                SEL_CUT_STATUS: O_RDATA <= {6'h00, cut_flag_r, 1'b0};
                default:        O_RDATA <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output paths

    logic [7:0] pin_nxt;
    logic [7:0] oe_nxt;
    logic [7:0] ena_all;
    logic [7:0] inv_all;

    assign ena_all = {ctrl_high_r[`RTOR_ENA_LSB +: 4], ctrl_low_r[`RTOR_ENA_LSB +: 4]};
    assign inv_all = {ctrl_high_r[`RTOR_INV_LSB +: 4], ctrl_low_r[`RTOR_INV_LSB +: 4]};

    for (genvar ch = 0; ch < 8; ch++) begin : g_ch
        rtor_cut_type mode;
        logic         wave;
        // Group of each channel: 0-2 in group 0, 3-5 in group 2, 6 in group 1, 7 in group 3
        localparam int GRP = (ch <= 2) ? 0 : (ch <= 5) ? 2 : (ch == 6) ? 1 : 3;
        assign mode = rtor_cut_type'(cut_state_r[2*GRP +: 2]);
        assign wave = src_sel_r[ch] ? I_TIMER_WAVE_B[ch] : I_TIMER_WAVE_A[ch];
        always_comb begin
            pin_nxt[ch] = (wave ^ inv_all[ch]) & ena_all[ch];
            oe_nxt[ch]  = ena_all[ch];
            if (cut_flag_r && cut_en_r[ch]) begin
                unique case (mode)
                    CUT_HIZ:  begin pin_nxt[ch] = 1'b0; oe_nxt[ch] = 1'b0; end
                    CUT_LOW:  begin pin_nxt[ch] = 1'b0; oe_nxt[ch] = 1'b1; end
                    CUT_HIGH: begin pin_nxt[ch] = 1'b1; oe_nxt[ch] = 1'b1; end
                    CUT_NONE: ;
                endcase
            end
        end
    end

    // Pins registered so outputs are glitch free toward the driver stage
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_PIN_OUT <= 8'h00;
            O_PIN_OE  <= 8'h00;
        end else if (I_CLK_EN) begin
            O_PIN_OUT <= pin_nxt;
            O_PIN_OE  <= oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    cut_set_a: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
        I_CLK_EN && I_EXTERNAL_CUTOFF_EVENT |=> cut_flag_r)
        else $error("cutoff flag not set by event");
    cut_clr_a: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
        I_CLK_EN && clr_req && cut_flag_r && !I_EXTERNAL_CUTOFF_EVENT |=> !cut_flag_r)
        else $error("cutoff flag not cleared");
    reset_zero_a: assert property (@(posedge I_SYS_CLK)
        $rose(rst_n) |-> (src_sel_r == 8'h00) && (cut_en_r == 8'h00)
            && (ctrl_low_r == 8'h00) && (ctrl_high_r == 8'h00)
            && (cut_state_r == 8'h00) && !cut_flag_r)
        else $error("registers not zero after reset");
    bit_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
        I_CLK_EN && I_WR && sel == SEL_SRC
            |=> ((src_sel_r ^ $past(src_sel_r)) & ~$past(I_WMASK)) == 8'h00)
        else $error("masked write touched other bits");
    // disabled channel 0 never driven without cutoff
    out_disable_a: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
        I_CLK_EN && !ena_all[0] && !cut_flag_r |=> !O_PIN_OE[0] && !O_PIN_OUT[0])
        else $error("disabled output driven");
    // source and inversion path on channel 0
    src_path_a: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
        I_CLK_EN && ena_all[0] && !cut_flag_r |=> O_PIN_OUT[0] ==
            (($past(src_sel_r[0]) ? $past(I_TIMER_WAVE_B[0]) : $past(I_TIMER_WAVE_A[0]))
            ^ $past(inv_all[0])))
        else $error("channel 0 path wrong");
    cut_ignore_a: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
        I_CLK_EN && !cut_en_r[7] |=> O_PIN_OE[7] == $past(ena_all[7]))
        else $error("cutoff applied to unenabled channel");
    // high code drives channel 7 high
    cut_high_a: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
        I_CLK_EN && cut_flag_r && cut_en_r[7] && cut_state_r[7:6] == 2'h2
            |=> O_PIN_OUT[7] && O_PIN_OE[7])
        else $error("cutoff high state wrong");
    cut_hiz_a: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
        I_CLK_EN && cut_flag_r && cut_en_r[3] && cut_state_r[5:4] == 2'h0 |=> !O_PIN_OE[3])
        else $error("cutoff float state wrong");

endmodule

/* File: dv/rtor_drive_stage.sv */
/*
 * Motor driver stage model that sits on the eight router output pins.
 * Assumes every gate input carries a pull-down resistor.
 */
`timescale 1ns/100ps
module rtor_drive_stage (
    input  wire logic [7:0] i_pin_out,
    input  wire logic [7:0] i_pin_oe,
    output logic      [7:0] o_gate
);
    // released pin level
    // A released pin falls to the pull-down, so a floating line never switches a gate on
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            o_gate[n] = i_pin_oe[n] ? i_pin_out[n] : 1'b0;
        end
    end
endmodule

/* File: dv/realtime_output_router_tb_top.sv */
/*
 * Self-checking bench for the real-time output router.
 * Assumes rtor_map.svh on the include path and the drive stage model.
 */
`timescale 1ns/100ps
`include "rtor_map.svh"
module realtime_output_router_tb_top;
    logic        clk, nrst, clk_en, wr, rd, event_in, flag;
    logic [19:0] addr;
    logic [7:0]  wmask, wdata, wave_a, wave_b, rdata, pin_out, pin_oe, gate;
    logic [7:0]  src, cen, cl, chi, cs;
    int          fail_count, checks_done;

    rtor_top rtor_top_i (.I_SYS_CLK(clk), .I_NRST(nrst), .I_CLK_EN(clk_en), .I_ADDR(addr),
        .I_WR(wr), .I_RD(rd), .I_WMASK(wmask), .I_WDATA(wdata), .I_TIMER_WAVE_A(wave_a),
        .I_TIMER_WAVE_B(wave_b), .I_EXTERNAL_CUTOFF_EVENT(event_in), .O_RDATA(rdata),
        .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe));
    rtor_drive_stage rtor_drive_stage_i (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_gate(gate));

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Masked write; shadow copy follows so expectations never come from the design
    task automatic wr_reg(input logic [19:0] a, input logic [7:0] m, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wmask = m;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        case (a)
            `RTOR_OFS_SRC_SEL:    src = (src & ~m) | (d & m);
            `RTOR_OFS_CUT_EN:     cen = (cen & ~m) | (d & m);
            `RTOR_OFS_CTRL_LOW:   cl = (cl & ~m) | (d & m);
            `RTOR_OFS_CTRL_HIGH:  chi = (chi & ~m) | (d & m);
            `RTOR_OFS_CUT_STATE:  cs = (cs & ~m) | (d & m);
            `RTOR_OFS_CUT_STATUS: if (m[0] && d[0]) flag = 1'b0;
            default: ;
        endcase
    endtask
    // Read strobe, then compare once the registered data has settled
    task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask
    // Expected {oe, out}: select, invert, enable, then per-group cutoff override
    function automatic logic [15:0] want();
        logic [7:0] o, e;
        logic [1:0] c;
        e = {chi[3:0], cl[3:0]};
        o = e & (((src & wave_b) | (~src & wave_a)) ^ {chi[7:4], cl[7:4]});
        for (int n = 0; n < 8; n++) begin
            c = (n < 3) ? cs[1:0] : (n < 6) ? cs[5:4] : (n == 6) ? cs[3:2] : cs[7:6];
            if (flag && cen[n] && c != 2'b11) begin
                e[n] = (c != 2'b00);
                o[n] = c[1];
            end
        end
        return {e, o};
    endfunction
    // Pins lag the configuration by one edge
    task automatic pin_chk();
        logic [15:0] w;
        @(negedge clk);
        w = want();
        chk(pin_out, w[7:0]);
        chk(pin_oe, w[15:8]);
        chk(gate, w[7:0]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Reset values of every register, and an unmapped address
    task automatic t_reset();
        for (int k = 0; k < 7; k++) begin
            rd_chk(`RTOR_OFS_SRC_SEL + 20'(k), 8'h00);
        end
        pin_chk();
    endtask
    // Source select, inversion and enable on both control registers
    task automatic t_route();
        wave_a = 8'h5A;
        wave_b = 8'hA5;
        wr_reg(`RTOR_OFS_SRC_SEL, 8'hFF, 8'hA6);
        wr_reg(`RTOR_OFS_CTRL_LOW, 8'hFF, 8'h3F);
        wr_reg(`RTOR_OFS_CTRL_HIGH, 8'hFF, 8'hC7);
        rd_chk(`RTOR_OFS_SRC_SEL, 8'hA6);
        rd_chk(`RTOR_OFS_CTRL_HIGH, 8'hC7);
        pin_chk();
        wave_a = 8'hF0;
        pin_chk();
    endtask
    // Single-bit writes leave the other bits alone
    task automatic t_bitwr();
        wr_reg(`RTOR_OFS_CTRL_LOW, 8'h01, 8'h00);
        wr_reg(`RTOR_OFS_SRC_SEL, 8'h10, 8'hFF);
        rd_chk(`RTOR_OFS_CTRL_LOW, 8'h3E);
        rd_chk(`RTOR_OFS_SRC_SEL, 8'hB6);
        pin_chk();
    endtask
    // Cutoff on channels 0-3 only, every state code, then the clear
    task automatic t_cutoff();
        wr_reg(`RTOR_OFS_CUT_EN, 8'hFF, 8'h0F);
        event_in = 1'b1;
        @(negedge clk);
        event_in = 1'b0;
        flag = 1'b1;
        rd_chk(`RTOR_OFS_CUT_STATUS, 8'h02);
        for (int c = 0; c < 4; c++) begin
            wr_reg(`RTOR_OFS_CUT_STATE, 8'hFF, {4{2'(c)}});
            pin_chk();
        end
        wr_reg(`RTOR_OFS_CUT_STATE, 8'hFF, 8'hE1);
        pin_chk();
        wr_reg(`RTOR_OFS_CUT_STATUS, 8'h01, 8'h01);
        rd_chk(`RTOR_OFS_CUT_STATUS, 8'h00);
        pin_chk();
    endtask
    // Clock enable low: writes, reads, events and wave changes are all held off
    task automatic t_freeze();
        logic [15:0] w;
        rd_chk(`RTOR_OFS_SRC_SEL, src);
        w = want();
        @(negedge clk);
        clk_en = 1'b0;
        wave_a = ~wave_a;
        wave_b = ~wave_b;
        addr = `RTOR_OFS_CUT_EN;
        wmask = 8'hFF;
        wdata = 8'h5A;
        wr = 1'b1;
        rd = 1'b1;
        event_in = 1'b1;
        repeat (2) @(negedge clk);
        {wr, rd, event_in} = 3'h0;
        chk(rdata, src);
        chk(pin_out, w[7:0]);
        chk(pin_oe, w[15:8]);
        clk_en = 1'b1;
        rd_chk(`RTOR_OFS_CUT_EN, cen);
        rd_chk(`RTOR_OFS_CUT_STATUS, {6'h00, flag, 1'b0});
        pin_chk();
    endtask
    // Cutoff enabled on all channels (0-2 left at the none code), groups of channels 6 and 7 too, then event against clear
    task automatic t_cut_groups();
        wr_reg(`RTOR_OFS_CUT_EN, 8'hFF, 8'hFF);
        wr_reg(`RTOR_OFS_CUT_STATE, 8'hFF, 8'h87);
        event_in = 1'b1;
        @(negedge clk);
        event_in = 1'b0;
        flag = 1'b1;
        pin_chk();
        // Clear and a new event in one cycle: the event must win
        @(negedge clk);
        addr = `RTOR_OFS_CUT_STATUS;
        wmask = 8'h01;
        wdata = 8'h01;
        wr = 1'b1;
        event_in = 1'b1;
        @(negedge clk);
        {wr, event_in} = 2'h0;
        rd_chk(`RTOR_OFS_CUT_STATUS, 8'h02);
        pin_chk();
        wr_reg(`RTOR_OFS_CUT_STATUS, 8'h01, 8'h01);
        rd_chk(`RTOR_OFS_CUT_STATUS, 8'h00);
        pin_chk();
    endtask
    // Reset in mid-run brings every register and pin back to zero
    task automatic t_rerun();
        @(negedge clk);
        nrst = 1'b0;
        @(negedge clk);
        chk(pin_out, 8'h00);
        chk(pin_oe, 8'h00);
        repeat (9) @(negedge clk);
        nrst = 1'b1;
        {src, cen, cl, chi, cs, flag} = 41'h0;
        repeat (4) @(negedge clk);
        t_reset();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic close_out();
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Reset, then the scenarios in turn
    initial begin
        {nrst, wr, rd, event_in, flag} = 5'h0;
        clk_en = 1'b1;
        {addr, wmask, wdata, wave_a, wave_b} = 52'h0;
        {src, cen, cl, chi, cs} = 40'h0;
        fail_count = 0;
        checks_done = 0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_route();
        t_bitwr();
        t_cutoff();
        t_freeze();
        t_cut_groups();
        t_rerun();
        close_out();
    end
    // Watchdog well beyond the fewer than two hundred cycles the scenarios need
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule
